// ===== src/cell_pack_protection_fsm.sv
// protection state controller for a single-cell pack
// What this block does
// - cell above overcharge detect level for overcharge delay: charge gate off
// - overcharge state keeps both sense resistors disconnected
// - overcharge release at release level, or detect level under load
// - with charger present, overcharge releases only when sense returns up
// - cell below overdischarge detect level for delay: discharge gate off
// - overdischarge connects sense pull-up, pull-down stays off
// - power-down variant sleeps near supply, wakes when charger pulls sense low
// - power-down variant without charger holds overdischarge despite release level
// - charger window releases at release level; deep negative at detect level
// - without power-down, no sleep; no charger releases at release level
// - sense at discharge overcurrent level for its delay: discharge gate off
// - discharge overcurrent connects pull-down, pull-up stays off
// - discharge overcurrent releases when sense falls back to level
// - sense at charge overcurrent level for its delay: charge gate off
// - charge overcurrent releases when sense returns up after charger removal
// - no charge overcurrent detection while overdischarged
// - no-overcurrent variant: sense below charger level for delay: abnormal charge
// - abnormal charge releases when sense difference is back under charger level
// - zero-volt charge holds charge gate at supply until release level
// - zero-volt charge beats charge overcurrent below overdischarge detect level
// - zero-volt inhibit holds charge gate low at or below inhibit level
// - all delays counted from a divided 4 kHz tick
// - normal state drives both gates on, both resistors off
`timescale 1ns/1ps
`default_nettype none
`include "cell_pack_params.svh"
module cell_pack_protection_fsm
  import cell_pack_pkg::*;
#(
  parameter bit         HAS_CHG_OC     = 1'b1,
  parameter bit         HAS_POWERDOWN  = 1'b1,
  parameter bit         ZERO_V_ENABLE  = 1'b1,
  parameter int         TICK_DIV       = `TICK_DIV,
  parameter logic [15:0] OVERCHG_TICKS = `OVERCHARGE_TICKS,
  parameter logic [15:0] OVERDIS_TICKS = `OVERDISCHARGE_TICKS,
  parameter logic [15:0] DIS_OC_TICKS  = `DISCH_OC_TICKS,
  parameter logic [15:0] CHG_OC_TICKS  = `CHG_OC_TICKS,
  parameter logic [15:0] SHRT_TICKS    = `SHORT_TICKS
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // cell voltage comparators
  input  wire logic cellAboveOverchargeDetect,
  input  wire logic cellBelowOverchargeRelease,
  input  wire logic cellBelowOverdischargeDetect,
  input  wire logic cellAtOverdischargeRelease,
  input  wire logic cellAtOrBelowZeroVoltInhibit,
  // sense node comparators
  input  wire logic senseAtDischargeOvercurrent,
  input  wire logic senseAtShortCircuit,
  input  wire logic senseAtOrBelowChargeOvercurrent,
  input  wire logic senseBelowChargerDetect,
  input  wire logic senseNearSupply,
  input  wire logic senseAtOrBelowWake,
  input  wire logic senseAtOrBelowNegWake,
  input  wire logic packAtZeroVoltChargeStart,
  // gate and resistor controls
  output logic      chargeGateOn,
  output logic      dischargeGateOn,
  output logic      senseToSupplyResistorOn,
  output logic      senseToGroundResistorOn,
  output logic      powerDown,
  output logic      zeroVoltChargeActive,
  output logic      chargeGateToPackNegative,
  // status
  output logic [6:0] protState
);
  // ********************************************
  // input synchronisers
  // ********************************************
  localparam int NIN = 13;
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [NIN-1:0] s3_q;
  logic [NIN-1:0] in_q;
  assign rawIn = {
    cellAboveOverchargeDetect,
    cellBelowOverchargeRelease,
    cellBelowOverdischargeDetect,
    cellAtOverdischargeRelease,
    cellAtOrBelowZeroVoltInhibit,
    senseAtDischargeOvercurrent,
    senseAtShortCircuit,
    senseAtOrBelowChargeOvercurrent,
    senseBelowChargerDetect,
    senseNearSupply,
    senseAtOrBelowWake,
    senseAtOrBelowNegWake,
    packAtZeroVoltChargeStart
  };

  genvar g;
  generate
    for (g = 0; g < NIN; g++)
    begin : g_sync
      always_ff @(posedge sys_clk)
      begin
        if (reset)
        begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          in_q[g] <= 1'b0;
        end
        else
        begin
          s1_q[g] <= rawIn[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g])
            in_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate

  logic ocDet, ocRel, odDet, odRel, zInh, dOc, shrt, cOc, chgLow, nearSup;
  logic wake, negWake, zStart;
  assign {
    ocDet,
    ocRel,
    odDet,
    odRel,
    zInh,
    dOc,
    shrt,
    cOc,
    chgLow,
    nearSup,
    wake,
    negWake,
    zStart
  } = in_q;

  // charger presence seen as sense pulled below ground
  logic chargerOn;
  assign chargerOn = HAS_CHG_OC ? cOc : chgLow;

  // ********************************************
  // delay timing
  // ********************************************
  logic tick;
  tick_divider #(.DIV(TICK_DIV)) u_tick (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (tick)
  );

  prot_state_t state_q, state_d;
  logic inNormal;
  assign inNormal = (state_q == ST_NORMAL);

  logic ocDone, odDone, dOcDone, shDone, cOcDone, abnDone;
  logic cOcCond;
  // suppressed when overdischarged or while the pack is at the zero-volt charge start level
  assign cOcCond = inNormal && HAS_CHG_OC && cOc && !odDet
                   && !(ZERO_V_ENABLE && zStart);

  delay_qualifier u_oc (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (tick),
    .cond    (inNormal && ocDet),
    .limit   (OVERCHG_TICKS),
    .done    (ocDone)
  );

  delay_qualifier u_od (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (tick),
    .cond    (inNormal && odDet),
    .limit   (OVERDIS_TICKS),
    .done    (odDone)
  );

  delay_qualifier u_doc (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (tick),
    .cond    (inNormal && dOc),
    .limit   (DIS_OC_TICKS),
    .done    (dOcDone)
  );

  delay_qualifier u_sh (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (tick),
    .cond    (inNormal && shrt),
    .limit   (SHRT_TICKS),
    .done    (shDone)
  );

  delay_qualifier u_coc (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (tick),
    .cond    (cOcCond),
    .limit   (CHG_OC_TICKS),
    .done    (cOcDone)
  );

  delay_qualifier u_abn (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (tick),
    .cond    (inNormal && !HAS_CHG_OC && chgLow),
    .limit   (OVERCHG_TICKS),
    .done    (abnDone)
  );

  // ********************************************
  // state transitions
  // ********************************************
  // overdischarge release decision used by the overdischarge state
  function automatic logic odRelease(input logic rel, input logic det,
                                     input logic chg, input logic nw);
    begin
      if (chg && nw)
        odRelease = !det;
      else if (chg)
        odRelease = rel;
      else
        odRelease = HAS_POWERDOWN ? 1'b0 : rel;
    end
  endfunction

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_NORMAL:
      begin
        if (dOcDone || shDone)
          state_d = ST_DISCH_OC;
        else if (odDone)
          state_d = ST_OVERDIS;
        else if (ocDone)
          state_d = ST_OVERCHG;
        else if (cOcDone)
          state_d = ST_CHG_OC;
        else if (abnDone)
          state_d = ST_ABN_CHG;
      end
      ST_OVERCHG:
      begin
        if (chargerOn)
          state_d = ST_OVERCHG;
        else if (dOc ? !ocDet : ocRel)
          state_d = ST_NORMAL;
      end
      ST_OVERDIS:
      begin
        // charger seen here as sense below the wake level
        if (HAS_POWERDOWN && nearSup && !wake)
          state_d = ST_POWERDOWN;
        else if (odRelease(odRel, odDet, wake, negWake))
          state_d = ST_NORMAL;
      end
      ST_POWERDOWN:
      begin
        if (wake)
          state_d = ST_OVERDIS;
      end
      ST_DISCH_OC:
      begin
        if (!dOc)
          state_d = ST_NORMAL;
      end
      ST_CHG_OC:
      begin
        if (!cOc)
          state_d = ST_NORMAL;
      end
      ST_ABN_CHG:
      begin
        if (!chgLow)
          state_d = ST_NORMAL;
      end
      default:
        state_d = ST_NORMAL;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      state_q <= ST_NORMAL;
    else
      state_q <= state_d;
  end

  // ********************************************
  // zero-volt charge
  // ********************************************
  logic zeroV_q;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      zeroV_q <= 1'b0;
    else if (!ZERO_V_ENABLE || odRel)
      zeroV_q <= 1'b0;
    else if (zStart)
      zeroV_q <= 1'b1;
  end

  // ********************************************
  // outputs
  // ********************************************
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      chargeGateOn             <= 1'b0;
      dischargeGateOn          <= 1'b0;
      senseToSupplyResistorOn  <= 1'b0;
      senseToGroundResistorOn  <= 1'b0;
      powerDown                <= 1'b0;
      zeroVoltChargeActive     <= 1'b0;
      chargeGateToPackNegative <= 1'b0;
      protState                <= 7'h00;
    end
    else
    begin
      chargeGateOn <= (zeroV_q ||
                       state_q inside {ST_NORMAL, ST_OVERDIS, ST_DISCH_OC,
                                       ST_POWERDOWN})
                      && !(!ZERO_V_ENABLE && zInh);
      dischargeGateOn <= state_q inside {ST_NORMAL, ST_OVERCHG,
                                         ST_CHG_OC, ST_ABN_CHG};
      senseToSupplyResistorOn <= state_q inside {ST_OVERDIS,
                                                 ST_POWERDOWN};
      senseToGroundResistorOn <= (state_q == ST_DISCH_OC);
      powerDown <= HAS_POWERDOWN && (state_q == ST_POWERDOWN);
      zeroVoltChargeActive <= zeroV_q;
      chargeGateToPackNegative <= !ZERO_V_ENABLE && zInh;
      protState <= state_q;
    end
  end
endmodule
`default_nettype wire

// ===== src/cell_pack_params.svh
// timing and width constants for the pack protection controller
`ifndef CELL_PACK_PARAMS_SVH
`define CELL_PACK_PARAMS_SVH
`define SYS_CLK_HZ          100000000
`define TICK_HZ             4000
`define TICK_DIV            (`SYS_CLK_HZ / `TICK_HZ)
`define OVERCHARGE_TICKS    16'h0fa0
`define OVERDISCHARGE_TICKS 16'h01f4
`define DISCH_OC_TICKS      16'h0030
`define CHG_OC_TICKS        16'h0020
`define SHORT_TICKS         16'h0002
`define DELAY_W             16
`endif

// ===== src/cell_pack_pkg.sv
// types for the pack protection controller
package cell_pack_pkg;
  typedef enum logic [6:0] {
    ST_NORMAL    = 7'b0000001,
    ST_OVERCHG   = 7'b0000010,
    ST_OVERDIS   = 7'b0000100,
    ST_DISCH_OC  = 7'b0001000,
    ST_CHG_OC    = 7'b0010000,
    ST_ABN_CHG   = 7'b0100000,
    ST_POWERDOWN = 7'b1000000
  } prot_state_t;
endpackage

// ===== src/tick_divider.sv
// divides the system clock down to a roughly 4 kHz tick pulse
`timescale 1ns/1ps
`default_nettype none
`include "cell_pack_params.svh"
module tick_divider #(
  parameter int DIV = `TICK_DIV
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // tick
  output logic      tick
);
  logic [31:0] cnt_q;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end
    else if (cnt_q == 32'(DIV - 1))
    begin
      cnt_q <= 32'h0;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== src/delay_qualifier.sv
// counts tick pulses while a condition holds; restarts when it drops
`timescale 1ns/1ps
`default_nettype none
`include "cell_pack_params.svh"
module delay_qualifier #(
  parameter int W = `DELAY_W
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset,
  // control
  input  wire logic         tick,
  input  wire logic         cond,
  input  wire logic [W-1:0] limit,
  // result
  output logic              done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge sys_clk)
  begin
    if (reset || !cond)
    begin
      cnt_q <= '0;
      done  <= 1'b0;
    end
    else if (tick && !done)
    begin
      cnt_q <= cnt_q + 1'b1;
      done  <= (cnt_q + 1'b1) >= limit;
    end
  end
endmodule
`default_nettype wire

// ===== verif/cell_pack_monitor.sv
// checker for the pack protection controller ports
`timescale 1ns/1ps
`default_nettype none
module cell_pack_monitor
  import cell_pack_pkg::*;
#(
  parameter int          TICK_DIV      = 4,
  parameter logic [15:0] OVERCHG_TICKS = 16'h0003
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset,
  // watched ports
  input wire logic       cellAboveOverchargeDetect,
  input wire logic       senseAtDischargeOvercurrent,
  input wire logic       chargeGateOn,
  input wire logic       dischargeGateOn,
  input wire logic       senseToSupplyResistorOn,
  input wire logic       senseToGroundResistorOn,
  input wire logic [6:0] protState
);
  // ********************************
  // properties
  // ********************************
  localparam int MINC = (int'(OVERCHG_TICKS) - 1) * TICK_DIV;
  int unsigned   highCnt_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  always_ff @(posedge sys_clk)
    highCnt_q <= (reset || !cellAboveOverchargeDetect) ? 32'h0 : highCnt_q + 32'h1;
  sequence s_oc_gone;
    (protState == ST_DISCH_OC && !senseAtDischargeOvercurrent) [*6];
  endsequence
  property p_nrm;
    protState == ST_NORMAL |-> chargeGateOn && dischargeGateOn
      && !senseToSupplyResistorOn && !senseToGroundResistorOn;
  endproperty
  a_nrm: assert property (p_nrm) else $error("normal drive wrong");
  property p_ovc;
    protState == ST_OVERCHG |-> !chargeGateOn && !senseToSupplyResistorOn
      && !senseToGroundResistorOn;
  endproperty
  a_ovc: assert property (p_ovc) else $error("overcharge drive wrong");
  property p_ovd;
    protState == ST_OVERDIS |-> !dischargeGateOn && senseToSupplyResistorOn
      && !senseToGroundResistorOn;
  endproperty
  a_ovd: assert property (p_ovd) else $error("overdischarge drive wrong");
  property p_doc;
    protState == ST_DISCH_OC |-> !dischargeGateOn && senseToGroundResistorOn
      && !senseToSupplyResistorOn;
  endproperty
  a_doc: assert property (p_doc) else $error("disch oc drive wrong");
  property p_coc;
    protState == ST_CHG_OC |-> !chargeGateOn;
  endproperty
  a_coc: assert property (p_coc) else $error("chg oc gate on");
  property p_dly;
    $rose(protState == ST_OVERCHG) |-> highCnt_q >= MINC;
  endproperty
  a_dly: assert property (p_dly) else $error("overcharge too early");
  property p_nco;
    protState == ST_OVERDIS |=> protState != ST_CHG_OC;
  endproperty
  a_nco: assert property (p_nco) else $error("chg oc in overdischarge");
  property p_pdn;
    $rose(protState == ST_POWERDOWN) |-> $past(protState) == ST_OVERDIS;
  endproperty
  a_pdn: assert property (p_pdn) else $error("power-down not from overdischarge");
  property p_rel;
    s_oc_gone |-> ##[0:4] protState == ST_NORMAL;
  endproperty
  a_rel: assert property (p_rel) else $error("disch oc not released");
endmodule
`default_nettype wire

// ===== verif/pack_far_side.sv
// far side model: load, charger and sense node
`timescale 1ns/1ps
`default_nettype none
module pack_far_side (
  // scenario knobs
  input  wire logic loadHeavy,
  input  wire logic chgOn,
  input  wire logic chgHeavy,
  // device controls
  input  wire logic dischargeGateOn,
  input  wire logic pullUpOn,
  // sense comparators
  output logic      senseOc,
  output logic      senseNear,
  output logic      senseWake,
  output logic      senseNegWake
);
  // ********************************
  // sense node levels
  // ********************************
  // heavy load lifts sense, gate off leaves it at supply
  assign senseOc      = loadHeavy && !chgOn;
  // pull-up drags an idle node to supply
  assign senseNear    = !chgOn && (pullUpOn || (loadHeavy && !dischargeGateOn));
  // charger pulls the node below ground
  assign senseWake    = chgOn;
  assign senseNegWake = chgOn && chgHeavy;
endmodule
`default_nettype wire

// ===== verif/tb_cell_pack_protection_fsm.sv
// testbench for the pack protection controller
`timescale 1ns/1ps
`default_nettype none
module tb_cell_pack_protection_fsm
  import cell_pack_pkg::*;
;
  // ********************************
  // stimulus and checks
  // ********************************
  localparam int DIV = 4;
  logic        sys_clk, reset, cellAboveOverchargeDetect, cellBelowOverchargeRelease;
  logic        cellBelowOverdischargeDetect, cellAtOverdischargeRelease;
  logic        cellAtOrBelowZeroVoltInhibit, senseAtDischargeOvercurrent, senseAtShortCircuit;
  logic        senseAtOrBelowChargeOvercurrent, senseNearSupply, senseAtOrBelowWake;
  logic        senseAtOrBelowNegWake, packAtZeroVoltChargeStart, ldHeavy, chgOn, chgHeavy;
  logic        chargeGateOn, dischargeGateOn, senseToSupplyResistorOn, senseToGroundResistorOn;
  logic        powerDown, zeroVoltChargeActive, chargeGateToPackNegative;
  logic [6:0]  protState;
  logic [31:0] rng = 32'hb3;
  int          badCount = 0;
  int          nChecks = 0;
  int          n;
  cell_pack_protection_fsm #(.TICK_DIV(DIV), .OVERCHG_TICKS(16'h0003),
    .OVERDIS_TICKS(16'h0003), .DIS_OC_TICKS(16'h0002), .CHG_OC_TICKS(16'h0002),
    .SHRT_TICKS(16'h0002)) i_cell_pack_protection_fsm (.sys_clk, .reset,
    .cellAboveOverchargeDetect, .cellBelowOverchargeRelease, .cellBelowOverdischargeDetect,
    .cellAtOverdischargeRelease, .cellAtOrBelowZeroVoltInhibit, .senseAtDischargeOvercurrent,
    .senseAtShortCircuit, .senseAtOrBelowChargeOvercurrent,
    .senseBelowChargerDetect(senseAtOrBelowWake), .senseNearSupply, .senseAtOrBelowWake,
    .senseAtOrBelowNegWake, .packAtZeroVoltChargeStart, .chargeGateOn, .dischargeGateOn,
    .senseToSupplyResistorOn, .senseToGroundResistorOn, .powerDown,
    .zeroVoltChargeActive, .chargeGateToPackNegative, .protState);
  pack_far_side i_pack_far_side (.loadHeavy(ldHeavy), .chgOn(chgOn), .chgHeavy(chgHeavy),
    .dischargeGateOn(dischargeGateOn), .pullUpOn(senseToSupplyResistorOn),
    .senseOc(senseAtDischargeOvercurrent), .senseNear(senseNearSupply),
    .senseWake(senseAtOrBelowWake), .senseNegWake(senseAtOrBelowNegWake));
  assign senseAtOrBelowChargeOvercurrent = senseAtOrBelowNegWake;
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic inWin(input int c, input int t);
    return c >= (t - 1) * DIV && c <= (t + 1) * DIV + 6;
  endfunction
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [6:0] got, input logic [6:0] exp, input string what);
    nChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic waitState(input logic [6:0] st);
    n = 0;
    while (protState !== st && n < 400)
    begin
      step(1);
      n++;
    end
    check(protState, st, "state reached");
    if (protState !== st)
      summarize();
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    {cellAboveOverchargeDetect, cellBelowOverchargeRelease, cellBelowOverdischargeDetect} = '0;
    {cellAtOverdischargeRelease, cellAtOrBelowZeroVoltInhibit, senseAtShortCircuit} = '0;
    {packAtZeroVoltChargeStart, ldHeavy, chgOn, chgHeavy} = '0;
    reset = 1'b1;
    step(10);
    reset = 1'b0;
    step(3);
    check({3'h0, chargeGateOn, dischargeGateOn, senseToSupplyResistorOn,
      senseToGroundResistorOn}, 7'h0c, "normal drive");
    repeat (4)
    begin
      cellAboveOverchargeDetect = 1'b1;
      step(2 + int'(xs() % 6));
      cellAboveOverchargeDetect = 1'b0;
      step(5);
    end
    check(protState, ST_NORMAL, "bursts ignored");
    cellAboveOverchargeDetect = 1'b1;
    waitState(ST_OVERCHG);
    check({6'h0, inWin(n, 3)}, 7'h01, "overcharge delay");
    check({3'h0, chargeGateOn, dischargeGateOn, senseToSupplyResistorOn,
      senseToGroundResistorOn}, 7'h04, "overcharge drive");
    {cellAboveOverchargeDetect, cellBelowOverchargeRelease, chgOn, chgHeavy} = 4'h7;
    step(20);
    check(protState, ST_OVERCHG, "held by charger");
    {chgOn, chgHeavy} = 2'h0;
    waitState(ST_NORMAL);
    cellBelowOverchargeRelease = 1'b0;
    $display("test overcharge done");
    cellBelowOverdischargeDetect = 1'b1;
    waitState(ST_OVERDIS);
    check({4'h0, dischargeGateOn, senseToSupplyResistorOn, senseToGroundResistorOn},
      7'h02, "overdischarge drive");
    waitState(ST_POWERDOWN);
    check({6'h0, powerDown}, 7'h01, "power-down flag");
    {cellBelowOverdischargeDetect, cellAtOverdischargeRelease} = 2'h1;
    step(20);
    check({6'h0, protState == ST_NORMAL}, 7'h00, "no release without charger");
    chgOn = 1'b1;
    waitState(ST_NORMAL);
    {chgOn, cellAtOverdischargeRelease} = 2'h0;
    $display("test overdischarge done");
    ldHeavy = 1'b1;
    waitState(ST_DISCH_OC);
    check({4'h0, dischargeGateOn, senseToSupplyResistorOn, senseToGroundResistorOn},
      7'h01, "disch oc drive");
    ldHeavy = 1'b0;
    waitState(ST_NORMAL);
    $display("test discharge overcurrent done");
    {chgOn, chgHeavy} = 2'h3;
    waitState(ST_CHG_OC);
    check({6'h0, chargeGateOn}, 7'h00, "chg oc gate");
    {chgOn, chgHeavy} = 2'h0;
    waitState(ST_NORMAL);
    $display("test charge overcurrent done");
    {packAtZeroVoltChargeStart, cellAtOrBelowZeroVoltInhibit} = 2'h3;
    step(10);
    check({5'h0, zeroVoltChargeActive, chargeGateToPackNegative},
      7'h02, "zero-volt start");
    {chgOn, chgHeavy} = 2'h3;
    step(40);
    check(protState, ST_NORMAL, "zero-volt beats chg oc");
    check({6'h0, chargeGateOn}, 7'h01, "zero-volt gate held");
    {chgOn, chgHeavy} = 2'h0;
    step(10);
    cellAtOverdischargeRelease = 1'b1;
    step(10);
    check({6'h0, zeroVoltChargeActive}, 7'h00, "zero-volt released");
    {packAtZeroVoltChargeStart, cellAtOrBelowZeroVoltInhibit} = 2'h0;
    cellAtOverdischargeRelease = 1'b0;
    $display("test zero-volt done");
    summarize();
  end
endmodule
bind cell_pack_protection_fsm cell_pack_monitor #(.TICK_DIV(TICK_DIV),
  .OVERCHG_TICKS(OVERCHG_TICKS)) i_cell_pack_monitor (.sys_clk, .reset,
  .cellAboveOverchargeDetect, .senseAtDischargeOvercurrent, .chargeGateOn, .dischargeGateOn,
  .senseToSupplyResistorOn, .senseToGroundResistorOn, .protState);
`default_nettype wire
